// *** shared/scic_pkg.sv ***
// Shared constants and types of the smart card interface control block.
package scic_pkg;

    // Timing.
    localparam int unsigned PCLK_HZ = 10_000_000;
    localparam int unsigned DEBOUNCE_MS = 8;
    localparam int unsigned DEBOUNCE_CYCLES = PCLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned EXT_CLK_MAX_HZ = 18_000_000;
    localparam logic [1:0] DEACT_STEPS = 2'h3;

    // Divide select code to log2 of the ratio, two bits per code, code 0 in the low bits.
    localparam logic [7:0] DIV_LOG2_MAP = 8'hE4;

    // Register byte offsets.
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_CLR = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_EN = 12'h010;

    // Field positions.
    localparam int unsigned CTRL_SOFT_DEACT = 0;
    localparam int unsigned STAT_PRESENT = 0;
    localparam int unsigned STAT_ACTIVE = 1;
    localparam int unsigned STAT_LEVEL_5V = 2;
    localparam int unsigned STAT_FAULT = 3;
    localparam int unsigned STAT_DIV_LSB = 4;
    localparam int unsigned IRQ_PRES = 0;
    localparam int unsigned IRQ_OVERLOAD = 1;
    localparam int unsigned IRQ_OVERHEAT = 2;
    localparam int unsigned IRQ_SUPPLY = 3;
    localparam int unsigned IRQ_W = 4;

    // Reset values.
    localparam logic CTRL_RESET = 1'h0;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;

    typedef enum logic [1:0] {
        SCIC_IDLE,
        SCIC_ACTIVE,
        SCIC_DEACT
    } scic_fsm_t;

    typedef enum logic [1:0] {
        SCIC_DIR_IDLE,
        SCIC_DIR_HOST,
        SCIC_DIR_CARD
    } scic_dir_t;

    typedef struct packed {
        logic overload;
        logic overheat;
        logic supply_loss;
    } scic_fault_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } scic_apb_req_t;

endpackage : scic_pkg

// *** core/scic_clkdiv.sv ***
// Card clock divider driven from the sampled external clock.
`timescale 1ns/1ps
module scic_clkdiv #(
    parameter logic [7:0] DIV_MAP = scic_pkg::DIV_LOG2_MAP
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control.
    input wire logic external_clock_in,
    input wire logic [1:0] divide_select,
    input wire logic run,
    // Card side.
    output logic card_clock_out
);

    typedef struct packed {
        logic prev;
        logic [2:0] cnt;
        logic div;
        logic clk;
    } scic_div_state_t;

    scic_div_state_t s;
    scic_div_state_t next_s;
    logic [1:0] log2_ratio;
    logic [2:0] half;
    logic rise;

    // The external clock is sampled, so it must stay below half the pclk rate.
    always_comb begin
        next_s = s;
        log2_ratio = DIV_MAP[{divide_select, 1'b0} +: 2];
        half = 3'(3'h1 << (log2_ratio - 2'h1));
        rise = external_clock_in & ~s.prev;
        next_s.prev = external_clock_in;
        if (!run) begin
            next_s.cnt = 3'h0;
            next_s.div = 1'b0;
        end else if (rise) begin
            if (s.cnt == half - 3'h1) begin
                next_s.cnt = 3'h0;
                next_s.div = ~s.div;
            end else begin
                next_s.cnt = s.cnt + 3'h1;
            end
        end
        if (log2_ratio == 2'h0) begin
            next_s.clk = run & external_clock_in;
        end else begin
            next_s.clk = run & next_s.div;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign card_clock_out = s.clk;

endmodule : scic_clkdiv

// *** core/scic_debounce.sv ***
// Card presence debounce filter.
`timescale 1ns/1ps
module scic_debounce #(
    parameter int unsigned CYCLES = scic_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Presence.
    input wire logic raw_present,
    output logic present
);

    localparam int unsigned CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic present;
    } scic_deb_state_t;

    scic_deb_state_t s;
    scic_deb_state_t next_s;

    // Removal is reported at once so that deactivation is never delayed.
    always_comb begin
        next_s = s;
        if (!raw_present) begin
            next_s.cnt = '0;
            next_s.present = 1'b0;
        end else if (!s.present) begin
            if (s.cnt == CW'(CYCLES - 1)) begin
                next_s.present = 1'b1;
            end else begin
                next_s.cnt = s.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign present = s.present;

endmodule : scic_debounce

// *** core/scic_top.sv ***
// Smart card interface control: activation, relay, faults, interrupt and APB registers.
//
// Functional notes
// - Card clock is external clock divided by 1, 2, 4 or 8.
// - Card clock comes only from the external clock through the divider.
// - Low on the active-low presence input means a card is inserted.
// - High on the active-high presence input means a card is inserted.
// - Insertion is reported only after a debounce of about 8 ms.
// - Card reset follows the host reset input.
// - Three open-drain serial lines are relayed both ways, idling high.
// - Overload, overheat, card removal or supply loss deactivate the card.
// - Presence changes and faults raise the interrupt.
// - Supply level select high asks 5 V, low asks 3 V.
// - Activation starts on a falling command edge with a card present.
// - The interrupt output is active low.
// - All card outputs are off while the host supply is low.
`timescale 1ns/1ps
module scic_top #(
    parameter int unsigned DEBOUNCE_CYCLES = scic_pkg::DEBOUNCE_CYCLES,
    parameter logic [7:0] DIV_MAP = scic_pkg::DIV_LOG2_MAP
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host control pins.
    input wire logic external_clock_in,
    input wire logic divide_select_lsb,
    input wire logic divide_select_msb,
    input wire logic card_supply_level_select,
    input wire logic activation_command_n,
    input wire logic host_reset_in,
    input wire logic host_supply_ok,
    output logic interrupt_n,
    // Presence and fault inputs.
    input wire logic card_presence_in_n,
    input wire logic card_presence_in,
    input wire scic_pkg::scic_fault_t fault_in,
    // Host side serial lines: 0 serial, 1 aux a, 2 aux b.
    input wire logic [2:0] host_line_in,
    output logic [2:0] host_line_out,
    output logic [2:0] host_line_oe,
    // Card side serial lines: 0 card_serial_line, 1 card_aux_line_a, 2 card_aux_line_b.
    input wire logic [2:0] card_line_in,
    output logic [2:0] card_line_out,
    output logic [2:0] card_line_oe,
    // Card power and control.
    output logic card_clock_out,
    output logic card_reset_out,
    output logic card_supply_en,
    output logic card_supply_5v
);

    typedef struct packed {
        scic_pkg::scic_fsm_t fsm;
        logic [1:0] step;
        logic prev_cmd_n;
        logic prev_present;
        scic_pkg::scic_fault_t prev_fault;
        logic soft_deact;
        logic [scic_pkg::IRQ_W-1:0] irq_stat;
        logic [scic_pkg::IRQ_W-1:0] irq_en;
        logic irq_n;
        logic card_reset;
        logic supply_en;
        logic supply_5v;
        scic_pkg::scic_dir_t [2:0] dir;
        logic [31:0] prdata;
        logic pslverr;
    } scic_top_state_t;

    scic_top_state_t s;
    scic_top_state_t next_s;
    scic_pkg::scic_apb_req_t req;
    scic_pkg::scic_fault_t fault_now;
    logic raw_present;
    logic present;
    logic any_fault;
    logic link_on;
    logic setup;
    logic wr;
    logic cmd_fall;
    logic [scic_pkg::IRQ_W-1:0] ev;
    logic [scic_pkg::IRQ_W-1:0] clr;
    logic [31:0] rdata;
    logic hit;
    logic next_run;
    logic link_next;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // Either presence input may signal a card; the unused one is strapped inactive.
    assign raw_present = ~card_presence_in_n | card_presence_in;

    scic_debounce #(
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .pclk(pclk),
        .presetn(presetn),
        .raw_present(raw_present),
        .present(present)
    );

    scic_clkdiv #(
        .DIV_MAP(DIV_MAP)
    ) u_clkdiv (
        .pclk(pclk),
        .presetn(presetn),
        .external_clock_in(external_clock_in),
        .divide_select({divide_select_msb, divide_select_lsb}),
        .run(next_run),
        .card_clock_out(card_clock_out)
    );

    // A host supply drop counts as supply loss alongside the card supply fault.
    always_comb begin
        fault_now = fault_in;
        fault_now.supply_loss = fault_in.supply_loss | ~host_supply_ok;
        any_fault = fault_now.overload | fault_now.overheat | fault_now.supply_loss;
    end

    assign setup = req.psel & ~req.penable;
    assign wr = req.psel & req.penable & req.pwrite;
    assign cmd_fall = s.prev_cmd_n & ~activation_command_n;
    assign link_on = (s.fsm == scic_pkg::SCIC_ACTIVE);

    // Read mux and address decode.
    always_comb begin
        rdata = 32'h00000000;
        hit = 1'b1;
        case (req.paddr)
            scic_pkg::ADDR_CTRL: begin
                rdata[scic_pkg::CTRL_SOFT_DEACT] = s.soft_deact;
            end
            scic_pkg::ADDR_STATUS: begin
                rdata[scic_pkg::STAT_PRESENT] = present;
                rdata[scic_pkg::STAT_ACTIVE] = link_on;
                rdata[scic_pkg::STAT_LEVEL_5V] = s.supply_5v;
                rdata[scic_pkg::STAT_FAULT] = any_fault;
                rdata[scic_pkg::STAT_DIV_LSB +: 2] = {divide_select_msb, divide_select_lsb};
            end
            scic_pkg::ADDR_IRQ_STAT: begin
                rdata[scic_pkg::IRQ_W-1:0] = s.irq_stat;
            end
            scic_pkg::ADDR_IRQ_CLR: begin
                rdata = 32'h00000000;
            end
            scic_pkg::ADDR_IRQ_EN: begin
                rdata[scic_pkg::IRQ_W-1:0] = s.irq_en;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Events that set sticky interrupt status bits.
    always_comb begin
        ev = '0;
        ev[scic_pkg::IRQ_PRES] = present ^ s.prev_present;
        ev[scic_pkg::IRQ_OVERLOAD] = fault_now.overload & ~s.prev_fault.overload;
        ev[scic_pkg::IRQ_OVERHEAT] = fault_now.overheat & ~s.prev_fault.overheat;
        ev[scic_pkg::IRQ_SUPPLY] = fault_now.supply_loss & ~s.prev_fault.supply_loss;
        clr = '0;
        if (wr && req.paddr == scic_pkg::ADDR_IRQ_CLR) begin
            clr = req.pwdata[scic_pkg::IRQ_W-1:0];
        end
    end

    always_comb begin
        next_s = s;
        next_s.prev_cmd_n = activation_command_n;
        next_s.prev_present = present;
        next_s.prev_fault = fault_now;

        // Register writes take effect in the access phase.
        if (wr && req.paddr == scic_pkg::ADDR_CTRL) begin
            next_s.soft_deact = req.pwdata[scic_pkg::CTRL_SOFT_DEACT];
        end
        if (wr && req.paddr == scic_pkg::ADDR_IRQ_EN) begin
            next_s.irq_en = req.pwdata[scic_pkg::IRQ_W-1:0];
        end
        // A new event beats a clear written in the same cycle.
        next_s.irq_stat = (s.irq_stat & ~clr) | ev;

        // Read data and error are settled in the setup phase, ready for the access edge.
        if (setup) begin
            next_s.prdata = req.pwrite ? 32'h00000000 : rdata;
            next_s.pslverr = ~hit;
        end

        case (s.fsm)
            scic_pkg::SCIC_IDLE: begin
                next_s.step = 2'h0;
                if (cmd_fall && present && !any_fault && !s.soft_deact) begin
                    next_s.fsm = scic_pkg::SCIC_ACTIVE;
                end
            end
            scic_pkg::SCIC_ACTIVE: begin
                if (any_fault || !present || activation_command_n || s.soft_deact) begin
                    next_s.fsm = scic_pkg::SCIC_DEACT;
                    next_s.step = 2'h0;
                end
            end
            scic_pkg::SCIC_DEACT: begin
                // Reset drops first, then the clock stops, then the supply goes off.
                if (s.step == scic_pkg::DEACT_STEPS - 2'h1) begin
                    next_s.fsm = scic_pkg::SCIC_IDLE;
                end else begin
                    next_s.step = s.step + 2'h1;
                end
            end
            default: begin
                next_s.fsm = scic_pkg::SCIC_IDLE;
            end
        endcase

        next_s.card_reset = (next_s.fsm == scic_pkg::SCIC_ACTIVE) & host_reset_in;
        // The divider gets the next run state, so the card clock stops on the same edge
        // as the supply when the host supply drops.
        next_run = host_supply_ok & ((next_s.fsm == scic_pkg::SCIC_ACTIVE) |
            (next_s.fsm == scic_pkg::SCIC_DEACT && next_s.step == 2'h0));
        // A supply cut by undervoltage stays off for the rest of the deactivation.
        next_s.supply_en = host_supply_ok & ((next_s.fsm == scic_pkg::SCIC_ACTIVE) |
            (next_s.fsm == scic_pkg::SCIC_DEACT && s.supply_en));
        next_s.supply_5v = card_supply_level_select;

        // Direction is won by whichever side pulls low first, which stops the relay
        // from latching on its own echo.
        // Lines let go on the edge the link leaves the active state, no later than the supply drops.
        link_next = (next_s.fsm == scic_pkg::SCIC_ACTIVE);
        for (int i = 0; i < 3; i++) begin
            case (s.dir[i])
                scic_pkg::SCIC_DIR_IDLE: begin
                    if (link_next && !host_line_in[i]) begin
                        next_s.dir[i] = scic_pkg::SCIC_DIR_HOST;
                    end else if (link_next && !card_line_in[i]) begin
                        next_s.dir[i] = scic_pkg::SCIC_DIR_CARD;
                    end
                end
                scic_pkg::SCIC_DIR_HOST: begin
                    if (!link_next || host_line_in[i]) begin
                        next_s.dir[i] = scic_pkg::SCIC_DIR_IDLE;
                    end
                end
                scic_pkg::SCIC_DIR_CARD: begin
                    if (!link_next || card_line_in[i]) begin
                        next_s.dir[i] = scic_pkg::SCIC_DIR_IDLE;
                    end
                end
                default: begin
                    next_s.dir[i] = scic_pkg::SCIC_DIR_IDLE;
                end
            endcase
        end

        next_s.irq_n = ~|(next_s.irq_stat & next_s.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.fsm <= scic_pkg::SCIC_IDLE;
            s.prev_cmd_n <= 1'b1;
            s.soft_deact <= scic_pkg::CTRL_RESET;
            s.irq_en <= scic_pkg::IRQ_EN_RESET;
            s.irq_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Open-drain pads: each side only ever pulls low, the pull-up gives the high level.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_line
            assign card_line_out[g] = 1'b0;
            assign card_line_oe[g] = (s.dir[g] == scic_pkg::SCIC_DIR_HOST);
            assign host_line_out[g] = 1'b0;
            assign host_line_oe[g] = (s.dir[g] == scic_pkg::SCIC_DIR_CARD);
        end
    endgenerate

    assign pready = req.psel & req.penable;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign interrupt_n = s.irq_n;
    assign card_reset_out = s.card_reset;
    assign card_supply_en = s.supply_en;
    assign card_supply_5v = s.supply_5v & s.supply_en;

endmodule : scic_top

// *** dv/scic_chk.sv ***
// Assertion checker for the smart card interface control block.
`timescale 1ns/1ps
module scic_chk (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Host side.
    input wire logic activation_command_n,
    input wire logic host_reset_in,
    input wire logic host_supply_ok,
    input wire logic card_supply_level_select,
    input wire scic_pkg::scic_fault_t fault_in,
    input wire logic [2:0] host_line_in,
    input wire logic [2:0] host_line_oe,
    // Card side.
    input wire logic [2:0] card_line_oe,
    input wire logic card_clock_out,
    input wire logic card_reset_out,
    input wire logic card_supply_en,
    input wire logic card_supply_5v
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Reset goes low no later than the supply drops, so the card never sees reset high unpowered.
    sequence s_fault;
        card_supply_en && (|fault_in);
    endsequence
    sequence s_shutdown;
        !card_reset_out ##[0:4] !card_supply_en;
    endsequence
    AST_FAULT_DEACT: assert property (s_fault |=> s_shutdown)
        else $error("fault left card powered");
    AST_UVLO_OFF: assert property (
        !host_supply_ok |=> !card_supply_en && !card_clock_out)
        else $error("card powered in undervoltage");
    AST_NO_SPURIOUS_ON: assert property (
        activation_command_n && !card_supply_en |=> !card_supply_en)
        else $error("card powered without command");
    AST_RESET_FOLLOW: assert property (
        $rose(card_reset_out) |-> $past(host_reset_in) && card_supply_en)
        else $error("card reset rose alone");
    AST_IDLE_LINES: assert property (
        !card_supply_en |-> (card_line_oe | host_line_oe) == 3'h0)
        else $error("line driven while unpowered");
    AST_LEVEL: assert property (
        card_supply_5v == (card_supply_en && $past(card_supply_level_select)))
        else $error("supply level wrong");
    AST_RELAY: assert property (
        $rose(card_line_oe[1]) |-> !$past(host_line_in[1]))
        else $error("card line pulled without host low");
    AST_CLK_GATED: assert property (card_clock_out |-> card_supply_en)
        else $error("card clock while unpowered");
endmodule : scic_chk

bind scic_top scic_chk i_chk (
    .pclk, .presetn, .activation_command_n, .host_reset_in, .host_supply_ok,
    .card_supply_level_select, .fault_in, .host_line_in, .host_line_oe, .card_line_oe,
    .card_clock_out, .card_reset_out, .card_supply_en, .card_supply_5v
);

// *** dv/scic_card_model.sv ***
// Smart card stand-in: pulls its lines low on command and counts card clock edges.
`timescale 1ns/1ps
module scic_card_model (
    // Clock.
    input wire logic pclk,
    // Card contacts.
    input wire logic card_supply_en,
    input wire logic card_clock_out,
    input wire logic [2:0] card_line_oe,
    input wire logic [2:0] pull_low,
    output logic [2:0] card_line_in,
    output logic [31:0] clk_edges
);
    logic clk_q = 1'h0;
    // An unpowered card cannot pull a line, so the pull-up wins then.
    assign card_line_in = ~(card_line_oe | (pull_low & {3{card_supply_en}}));
    initial clk_edges = 32'h0;
    always @(posedge pclk) begin
        clk_q <= card_clock_out;
        if (card_clock_out && !clk_q) begin
            clk_edges <= clk_edges + 32'h1;
        end
    end
endmodule : scic_card_model

// *** dv/scic_top_tb.sv ***
// Self-checking testbench of the smart card interface control block.
`timescale 1ns/1ps
module scic_top_tb;
    typedef struct packed {
        logic [1:0] code;
        logic lvl;
        logic [7:0] edges;
    } scic_row_t;
    // Card clock edges expected in 256 cycles of a quarter-rate input clock.
    scic_row_t rows [4] = '{'{2'h0, 1'h1, 8'h40}, '{2'h1, 1'h0, 8'h20},
        '{2'h2, 1'h1, 8'h10}, '{2'h3, 1'h0, 8'h08}};
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, clk_edges, rd, e0;
    logic pready, pslverr, err, external_clock_in, interrupt_n;
    logic [1:0] ext_cnt = 2'h0;
    logic divide_select_lsb = 1'h0, divide_select_msb = 1'h0;
    logic card_supply_level_select = 1'h0, activation_command_n = 1'h1;
    logic host_reset_in = 1'h0, host_supply_ok = 1'h1;
    logic card_presence_in_n = 1'h1, card_presence_in = 1'h0;
    scic_pkg::scic_fault_t fault_in = 3'h0;
    logic [2:0] host_pull = 3'h0, card_pull = 3'h0;
    logic [2:0] host_line_in, host_line_oe, card_line_in, card_line_oe;
    logic [2:0] host_line_out, card_line_out;
    logic card_clock_out, card_reset_out, card_supply_en, card_supply_5v;
    int bad_count = 0;
    int n_tests = 0;
    assign external_clock_in = ext_cnt[1];
    assign host_line_in = ~(host_line_oe | host_pull);
    always @(posedge pclk) begin
        ext_cnt <= ext_cnt + 2'h1;
    end
    scic_top #(.DEBOUNCE_CYCLES(16)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .external_clock_in, .divide_select_lsb, .divide_select_msb,
        .card_supply_level_select, .activation_command_n, .host_reset_in,
        .host_supply_ok, .interrupt_n, .card_presence_in_n, .card_presence_in, .fault_in,
        .host_line_in, .host_line_out, .host_line_oe, .card_line_in, .card_line_out,
        .card_line_oe, .card_clock_out, .card_reset_out, .card_supply_en, .card_supply_5v
    );
    scic_card_model i_card (.pclk, .card_supply_en, .card_clock_out, .card_line_oe,
        .pull_low(card_pull), .card_line_in, .clk_edges);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic activate;
        activation_command_n <= 1'h1;
        repeat (2) @(posedge pclk);
        activation_command_n <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask : activate
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        chk({31'h0, interrupt_n}, 32'h1);
        apb(1'h0, scic_pkg::ADDR_IRQ_EN, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 12'h020, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'h1, scic_pkg::ADDR_IRQ_EN, 32'hF);
        card_presence_in <= 1'h1;
        repeat (24) @(posedge pclk);
        chk({31'h0, interrupt_n}, 32'h0);
        apb(1'h1, scic_pkg::ADDR_IRQ_CLR, 32'hF);
        repeat (2) @(posedge pclk);
        chk({31'h0, interrupt_n}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            {divide_select_msb, divide_select_lsb} <= rows[i].code;
            card_supply_level_select <= rows[i].lvl;
            activate();
            e0 = clk_edges;
            repeat (256) @(posedge pclk);
            e0 = clk_edges - e0 + 32'h1 - {24'h0, rows[i].edges};
            chk({31'h0, (e0 <= 32'h2)}, 32'h1);
            chk({31'h0, card_supply_5v}, {31'h0, rows[i].lvl});
            apb(1'h0, scic_pkg::ADDR_STATUS, 32'h0);
            chk(rd, {26'h0, rows[i].code, 1'h0, rows[i].lvl, 2'h3});
            host_reset_in <= 1'h1;
            repeat (3) @(posedge pclk);
            chk({31'h0, card_reset_out}, 32'h1);
            host_reset_in <= 1'h0;
            activation_command_n <= 1'h1;
            repeat (8) @(posedge pclk);
        end
        activate();
        card_pull <= 3'h1;
        repeat (3) @(posedge pclk);
        chk({29'h0, host_line_oe}, 32'h1);
        chk({26'h0, host_line_out, card_line_out}, 32'h0);
        card_pull <= 3'h0;
        host_pull <= 3'h6;
        repeat (3) @(posedge pclk);
        chk({26'h0, host_line_oe, card_line_oe}, 32'h6);
        host_pull <= 3'h0;
        apb(1'h1, scic_pkg::ADDR_IRQ_CLR, 32'hF);
        fault_in <= 3'h4;
        repeat (8) @(posedge pclk);
        chk({31'h0, card_supply_en}, 32'h0);
        fault_in <= 3'h0;
        apb(1'h0, scic_pkg::ADDR_IRQ_STAT, 32'h0);
        chk({rd[31:1], interrupt_n}, 32'h2);
        apb(1'h1, scic_pkg::ADDR_IRQ_CLR, 32'hF);
        activate();
        host_supply_ok <= 1'h0;
        repeat (2) @(posedge pclk);
        chk({29'h0, card_supply_en, card_clock_out, card_reset_out}, 32'h0);
        host_supply_ok <= 1'h1;
        apb(1'h0, scic_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h8);
        activate();
        card_presence_in <= 1'h0;
        repeat (8) @(posedge pclk);
        chk({31'h0, card_supply_en}, 32'h0);
        activate();
        chk({31'h0, card_supply_en}, 32'h0);
        card_presence_in_n <= 1'h0;
        repeat (10) @(posedge pclk);
        card_presence_in_n <= 1'h1;
        @(posedge pclk);
        card_presence_in_n <= 1'h0;
        repeat (10) @(posedge pclk);
        apb(1'h0, scic_pkg::ADDR_STATUS, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        repeat (8) @(posedge pclk);
        apb(1'h0, scic_pkg::ADDR_STATUS, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        chk({31'h0, card_supply_en}, 32'h0);
        activate();
        chk({31'h0, card_supply_en}, 32'h1);
        apb(1'h1, scic_pkg::ADDR_CTRL, 32'h1);
        repeat (8) @(posedge pclk);
        chk({31'h0, card_supply_en}, 32'h0);
        apb(1'h1, scic_pkg::ADDR_CTRL, 32'h0);
        apb(1'h1, scic_pkg::ADDR_IRQ_CLR, 32'hF);
        apb(1'h1, scic_pkg::ADDR_IRQ_EN, 32'h0);
        fault_in <= 3'h2;
        repeat (3) @(posedge pclk);
        chk({31'h0, interrupt_n}, 32'h1);
        apb(1'h1, scic_pkg::ADDR_IRQ_EN, 32'h4);
        repeat (2) @(posedge pclk);
        chk({31'h0, interrupt_n}, 32'h0);
        apb(1'h1, scic_pkg::ADDR_IRQ_CLR, 32'h4);
        repeat (2) @(posedge pclk);
        chk({31'h0, interrupt_n}, 32'h1);
        wrap_up();
    end
endmodule : scic_top_tb
